// file: lcd_seg_ctrl.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "lcd_defs.svh"
module lcd_seg_ctrl #(
   parameter int ADDR_W = 18
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   input  wire logic                watch_tick,
   input  wire logic                prescaler_enable,
   input  wire logic [15:0]         port_out_data,
   input  wire logic [15:0]         port_mode,
   input  wire logic [15:0]         pullup_opt,
   input  wire logic [15:0]         pad_in,
   output logic [39:0][1:0]         seg_lvl,
   output logic [39:0]              seg_oe,
   output logic [3:0][1:0]          com_lvl,
   output logic [3:0]               com_oe,
   output logic [15:0]              pad_out,
   output logic [15:0]              pad_oe,
   output logic [15:0]              pullup_en,
   output logic [15:0]              port_rdata,
   output logic                     pwr_vdd_en,
   output logic                     pwr_bias_short,
   output logic                     low_voltage,
   output logic                     display_valid
);
   localparam int MW = 6;
   lcd_pkg::lcd_mode_t  mode_r;
   lcd_pkg::lcd_ctrl_t  ctrl_r;
   lcd_pkg::lcd_wst_t   wst_r;
   lcd_pkg::lcd_drive_t drv;
   logic [3:0]          mem_r [`LCD_NSEG];
   logic [ADDR_W-1:0]   awaddr_r;
   logic [31:0]         wdata_r;
   logic                wstrb0_r;
   logic                aw_got_r;
   logic                w_got_r;
   logic                wr_fire;
   logic [15:0]         widx;
   logic [15:0]         ridx;
   logic [MW-1:0]       wmem;
   logic [MW-1:0]       rmem;
   logic                w_is_mem;
   logic                r_is_mem;
   logic                rd_mem_r;
   logic [15:0]         pad_s1_r;
   logic [15:0]         pad_s2_r;
   logic [15:0]         seg_pin;
   logic [`LCD_NSEG-1:0] seg_en;
   logic [3:0]          split_eff;
   logic [1:0]          last_slot;
   logic                div_ok;
   logic                is_static;
   logic                half_bias;
   logic                disp_on;
   logic [1:0]          seg_sel_lv;
   logic [1:0]          seg_uns_lv;
   logic [1:0]          com_sel_lv;
   logic [1:0]          com_uns_lv;

   // ---------------- division decode ----------------
   always_comb begin
      div_ok    = 1'b1;
      is_static = 1'b0;
      half_bias = 1'b0;
      last_slot = 2'h3;
      case (mode_r.division_sel) // [RL1]
         `LCD_DIV_4W3B: last_slot = 2'h3;
         `LCD_DIV_3W3B: last_slot = 2'h2;
         `LCD_DIV_2W2B: begin
            last_slot = 2'h1;
            half_bias = 1'b1;
         end
         `LCD_DIV_3W2B: begin
            last_slot = 2'h2;
            half_bias = 1'b1;
         end
         `LCD_DIV_STAT: begin
            last_slot = 2'h0;
            is_static = 1'b1;
         end
         default: div_ok = 1'b0;
      endcase
   end

   lcd_frame_seq #(
      .PRE_W            (9)
   ) u_seq (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .watch_tick       (watch_tick),
      .prescaler_enable (prescaler_enable),
      .fclk_sel         (mode_r.frame_clk_sel),
      .last_slot        (last_slot),
      .drive            (drv)
   );

   // prohibited division codes blank the panel instead of guessing a mode
   assign disp_on = mode_r.display_enable && div_ok && drv.frame_run; // [RL3] [RL4]

   // drive levels: static swings rails only, 1/2 bias parks at mid, 1/3 at thirds
   always_comb begin
      com_sel_lv = drv.polarity ? `LCD_LV_VLCD : `LCD_LV_VSS; // [RL17]
      seg_sel_lv = drv.polarity ? `LCD_LV_VSS : `LCD_LV_VLCD;
      if (is_static || half_bias) begin
         seg_uns_lv = com_sel_lv;
         com_uns_lv = `LCD_LV_ONE;
      end else begin
         seg_uns_lv = drv.polarity ? `LCD_LV_TWO : `LCD_LV_ONE;
         com_uns_lv = drv.polarity ? `LCD_LV_ONE : `LCD_LV_TWO;
      end
   end

   // ---------------- pin split ----------------
   assign split_eff = (ctrl_r.pin_split > `LCD_SPLIT_MAX) ? 4'h0 : ctrl_r.pin_split;

   genvar gj;
   generate
      for (gj = 0; gj < `LCD_NPIN; gj++) begin : g_pin
         assign seg_pin[gj] = (gj / 2) < int'(split_eff); // [RL7]
      end
   endgenerate

   // fixed segments always drive; shared ones only when the split hands them over
   assign seg_en = {seg_pin, {`LCD_SEG_PIN0{1'b1}}}; // [RL7]

   // ---------------- segment and common outputs ----------------
   genvar gk;
   generate
      for (gk = 0; gk < `LCD_NSEG; gk++) begin : g_seg
         // segment k reads the byte counted down from the top of memory
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               seg_lvl[gk] <= `LCD_LV_VSS;
               seg_oe[gk]  <= 1'b0;
            end else begin
               // slot exceeds the active count only in the cycle after the count drops, so higher bits are otherwise unread
               if (disp_on && mem_r[`LCD_NSEG-1-gk][drv.slot]) begin // [RL11] [RL13] [RL15]
                  seg_lvl[gk] <= seg_sel_lv;
               end else begin
                  seg_lvl[gk] <= seg_uns_lv; // [RL3]
               end
               seg_oe[gk] <= seg_en[gk];
            end
         end
      end
      for (gk = 0; gk < `LCD_NCOM; gk++) begin : g_com
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               com_lvl[gk] <= `LCD_LV_VSS;
               com_oe[gk]  <= 1'b0;
            end else begin
               if (is_static || drv.slot == 2'(gk)) begin // [RL16]
                  com_lvl[gk] <= com_sel_lv;
               end else begin
                  com_lvl[gk] <= com_uns_lv;
               end
               com_oe[gk] <= div_ok && (is_static || 2'(gk) <= last_slot); // [RL16]
            end
         end
      end
   endgenerate

   // ---------------- shared port pins ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_s1_r <= '0;
         pad_s2_r <= '0;
      end else begin
         pad_s1_r <= pad_in;
         pad_s2_r <= pad_s1_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_out    <= '0;
         pad_oe     <= '0;
         pullup_en  <= '0;
         port_rdata <= '0;
      end else begin
         // port mode bit 0 selects output, but a segment pin still wins
         pad_out    <= port_out_data & ~seg_pin;
         pad_oe     <= ~port_mode & ~seg_pin; // [RL8]
         pullup_en  <= pullup_opt & ~seg_pin; // [RL10]
         port_rdata <= pad_s2_r & ~seg_pin; // [RL9]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_vdd_en     <= 1'b0;
         pwr_bias_short <= 1'b0;
         low_voltage    <= 1'b0;
         display_valid  <= 1'b0;
      end else begin
         pwr_vdd_en     <= {ctrl_r.ext_power_sel, ctrl_r.int_power_sel} == `LCD_PWR_VDD; // [RL6]
         pwr_bias_short <= {ctrl_r.ext_power_sel, ctrl_r.int_power_sel} == `LCD_PWR_BIAS;
         // the bit is passed on as written; changing it with the display on is unsafe
         low_voltage    <= mode_r.low_voltage_sel; // [RL5]
         display_valid  <= disp_on;
      end
   end

   // ---------------- AXI4-Lite write ----------------
   assign widx     = awaddr_r[17:2];
   assign wmem     = MW'(widx - `LCD_IDX_MEM_LO);
   assign w_is_mem = widx >= `LCD_IDX_MEM_LO && widx <= `LCD_IDX_MEM_HI; // [RL12]
   assign wr_fire  = wst_r == lcd_pkg::LCD_WS_COLLECT && aw_got_r && w_got_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_r    <= lcd_pkg::LCD_WS_COLLECT;
         awready  <= 1'b1;
         wready   <= 1'b1;
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= '0;
         wstrb0_r <= 1'b0;
         bvalid   <= 1'b0;
         bresp    <= `LCD_RESP_OKAY;
      end else begin
         case (wst_r)
            lcd_pkg::LCD_WS_COLLECT: begin
               if (awvalid && awready) begin
                  awaddr_r <= awaddr;
                  aw_got_r <= 1'b1;
                  awready  <= 1'b0;
               end
               if (wvalid && wready) begin
                  wdata_r  <= wdata;
                  wstrb0_r <= wstrb[0];
                  w_got_r  <= 1'b1;
                  wready   <= 1'b0;
               end
               if (wr_fire) begin
                  bvalid   <= 1'b1;
                  bresp    <= (awaddr_r[1:0] == 2'h0 && (w_is_mem || widx == `LCD_IDX_MODE
                               || widx == `LCD_IDX_CTRL || widx == `LCD_IDX_STAT))
                              ? `LCD_RESP_OKAY : `LCD_RESP_SLV;
                  aw_got_r <= 1'b0;
                  w_got_r  <= 1'b0;
                  wst_r    <= lcd_pkg::LCD_WS_RESP;
               end
            end
            lcd_pkg::LCD_WS_RESP: begin
               if (bready) begin
                  bvalid  <= 1'b0;
                  awready <= 1'b1;
                  wready  <= 1'b1;
                  wst_r   <= lcd_pkg::LCD_WS_COLLECT;
               end
            end
            default: wst_r <= lcd_pkg::LCD_WS_COLLECT;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= `LCD_MODE_RST; // [RL20]
         ctrl_r <= `LCD_CTRL_RST; // [RL20]
      end else if (wr_fire && wstrb0_r && awaddr_r[1:0] == 2'h0) begin
         if (widx == `LCD_IDX_MODE) begin
            mode_r <= wdata_r[7:0];
         end
         if (widx == `LCD_IDX_CTRL) begin
            ctrl_r <= {wdata_r[7:4], 2'h0, wdata_r[1:0]};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (wr_fire && wstrb0_r && w_is_mem && awaddr_r[1:0] == 2'h0) begin
         mem_r[wmem] <= wdata_r[3:0]; // [RL14]
      end
   end

   // ---------------- AXI4-Lite read ----------------
   assign ridx     = araddr[17:2];
   assign rmem     = MW'(ridx - `LCD_IDX_MEM_LO);
   assign r_is_mem = ridx >= `LCD_IDX_MEM_LO && ridx <= `LCD_IDX_MEM_HI;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready  <= 1'b1;
         rvalid   <= 1'b0;
         rdata    <= 32'h0000_0000;
         rresp    <= `LCD_RESP_OKAY;
         rd_mem_r <= 1'b0;
      end else if (arvalid && arready) begin
         arready  <= 1'b0;
         rvalid   <= 1'b1;
         rresp    <= `LCD_RESP_OKAY;
         rdata    <= 32'h0000_0000;
         rd_mem_r <= 1'b0;
         if (araddr[1:0] != 2'h0) begin
            rresp <= `LCD_RESP_SLV;
         end else if (r_is_mem) begin
            rdata    <= {28'h000_0000, mem_r[rmem]}; // [RL14]
            rd_mem_r <= 1'b1;
         end else if (ridx == `LCD_IDX_MODE) begin
            rdata <= {24'h00_0000, mode_r};
         end else if (ridx == `LCD_IDX_CTRL) begin
            rdata <= {24'h00_0000, ctrl_r};
         end else if (ridx == `LCD_IDX_STAT) begin
            rdata <= {28'h000_0000, drv.slot, drv.polarity, disp_on};
         end else begin
            rresp <= `LCD_RESP_SLV;
         end
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ---------------- checks ----------------
   sequence s_both_taken;
      aw_got_r && w_got_r && wst_r == lcd_pkg::LCD_WS_COLLECT;
   endsequence
   sequence s_resp_up;
      bvalid && !awready && !wready;
   endsequence

   chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      s_both_taken |=> s_resp_up) else $error("no write response after both halves");
   chk_mem_upper: assert property (@(posedge aclk) disable iff (!aresetn) // [RL14]
      rvalid && rd_mem_r |-> rdata[31:4] == 28'h000_0000)
      else $error("memory upper bits not zero");
   chk_seg_blank: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
      aresetn && !mode_r.display_enable |=> seg_lvl[0] == $past(seg_uns_lv))
      else $error("segment selected with display off");
   chk_pin_no_port: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
      $past(seg_pin[0]) |-> !pad_oe[0] && !pad_out[0])
      else $error("port path reaches segment pin");
   chk_read_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RL9]
      $past(seg_pin[`LCD_NPIN-1]) |-> !port_rdata[`LCD_NPIN-1])
      else $error("segment pin reads non-zero");
   chk_pullup_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
      seg_pin[1] |=> !pullup_en[1]) else $error("pull-up on segment pin");
   chk_com_open: assert property (@(posedge aclk) disable iff (!aresetn) // [RL16]
      mode_r.division_sel == `LCD_DIV_2W2B |=> com_oe[3:2] == 2'h0)
      else $error("unused common driven");
   chk_static_com: assert property (@(posedge aclk) disable iff (!aresetn) // [RL16]
      is_static [*2] |-> com_lvl[3] == com_lvl[0] && com_lvl[1] == com_lvl[0])
      else $error("static commons differ");
endmodule : lcd_seg_ctrl

// file: lcd_defs.svh
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH
// Behaviour
// RL1: division code 0..4 picks 4/3/2/3-way or static with 1/3 or 1/2 bias.
// RL2: frame clock is watch clock over 2^9, 2^8, 2^7 or 2^6 for codes 0..3.
// RL3: display disabled forces every segment to the unselect level.
// RL4: frame clock runs only while the watch prescaler enable is high.
// RL5: software changes the low-voltage bit only with the display off.
// RL6: power code 00 none, 01 main supply, 10 external bias pin shorted.
// RL7: pin split code n turns 2n shared pins from segment 24 into segments.
// RL8: a pin used as segment never carries the port output path.
// RL9: port read of a pin used as segment returns zero.
// RL10: pull-up is off on every pin used as segment.
// RL11: display memory is scanned continuously without software action.
// RL12: display memory spans FA58h to FA7Fh, one byte per segment.
// RL13: in common slot n each segment selects when its memory bit n is one.
// RL14: upper four memory bits store nothing, read zero; software writes zero.
// RL15: memory bits above the active common count are ignored.
// RL16: static drives all commons alike; unused commons are left open.
// RL17: drive polarity alternates so no pixel sees a net DC voltage.
// RL18: software starts watch timer, fills memory, sets split, then mode.
// RL19: sequencer steps active common slots, inverting polarity each frame.
// RL20: reset clears both control registers: display off, no power, ports.
`define LCD_IDX_MODE   16'hffb0
`define LCD_IDX_CTRL   16'hffb2
`define LCD_IDX_STAT   16'hffb4
`define LCD_IDX_MEM_LO 16'hfa58
`define LCD_IDX_MEM_HI 16'hfa7f
`define LCD_MODE_RST   8'h00
`define LCD_CTRL_RST   8'h00
`define LCD_DIV_4W3B   3'h0
`define LCD_DIV_3W3B   3'h1
`define LCD_DIV_2W2B   3'h2
`define LCD_DIV_3W2B   3'h3
`define LCD_DIV_STAT   3'h4
`define LCD_FCLK_MAX   3'h3
`define LCD_FDIV_EXP0  4'h9
`define LCD_PWR_VDD    2'h1
`define LCD_PWR_BIAS   2'h2
`define LCD_SPLIT_MAX  4'h8
`define LCD_SEG_PIN0   24
`define LCD_NSEG       40
`define LCD_NPIN       16
`define LCD_NCOM       4
`define LCD_LV_VSS     2'h0
`define LCD_LV_ONE     2'h1
`define LCD_LV_TWO     2'h2
`define LCD_LV_VLCD    2'h3
`define LCD_RESP_OKAY  2'h0
`define LCD_RESP_SLV   2'h2
`endif

// file: lcd_pkg.sv
package lcd_pkg;
   typedef struct packed {
      logic       display_enable;
      logic [2:0] frame_clk_sel;
      logic       low_voltage_sel;
      logic [2:0] division_sel;
   } lcd_mode_t;
   typedef struct packed {
      logic [3:0] pin_split;
      logic [1:0] zero_bits;
      logic       ext_power_sel;
      logic       int_power_sel;
   } lcd_ctrl_t;
   typedef struct packed {
      logic [1:0] slot;
      logic       polarity;
      logic       frame_run;
   } lcd_drive_t;
   typedef enum logic [1:0] {
      LCD_WS_COLLECT = 2'b01,
      LCD_WS_RESP    = 2'b10
   } lcd_wst_t;
endpackage : lcd_pkg

// file: lcd_frame_seq.sv
`timescale 1ns/1ps
`include "lcd_defs.svh"
module lcd_frame_seq #(
   parameter int PRE_W = 9
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          watch_tick,
   input  wire logic          prescaler_enable,
   input  wire logic [2:0]    fclk_sel,
   input  wire logic [1:0]    last_slot,
   output lcd_pkg::lcd_drive_t drive
);
   logic [PRE_W-1:0] pre_r;
   logic [PRE_W-1:0] mask;
   logic [3:0]       exp_w;
   logic [1:0]       slot_r;
   logic             pol_r;
   logic             run;
   logic             frame_tick;

   assign exp_w = `LCD_FDIV_EXP0 - {1'b0, fclk_sel};
   assign mask  = ~({PRE_W{1'b1}} << exp_w); // [RL2]
   // prohibited select codes stop the frame clock rather than guess a rate
   assign run        = prescaler_enable && (fclk_sel <= `LCD_FCLK_MAX); // [RL4]
   assign frame_tick = run && watch_tick && ((pre_r & mask) == mask);

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         pre_r <= '0;
      end else if (watch_tick) begin
         pre_r <= pre_r + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_r <= 2'h0;
         pol_r  <= 1'b0;
      end else if (slot_r > last_slot) begin
         slot_r <= 2'h0;
      end else if (frame_tick) begin
         if (slot_r == last_slot) begin
            slot_r <= 2'h0;
            pol_r  <= ~pol_r; // [RL17] [RL19]
         end else begin
            slot_r <= slot_r + 2'h1; // [RL19]
         end
      end
   end

   assign drive = '{slot: slot_r, polarity: pol_r, frame_run: run};

   chk_slot_bound: assert property (@(posedge aclk) disable iff (!aresetn) // [RL19]
      $past(slot_r <= last_slot) && $stable(last_slot) |-> slot_r <= last_slot)
      else $error("common slot beyond active count");
   chk_pol_frame: assert property (@(posedge aclk) disable iff (!aresetn) // [RL17]
      frame_tick && slot_r == last_slot |=> pol_r != $past(pol_r) && slot_r == 2'h0)
      else $error("polarity not inverted at frame end");
   chk_gate_stop: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
      !prescaler_enable && slot_r <= last_slot |=> $stable(slot_r) && $stable(pol_r))
      else $error("sequencer moved with prescaler disabled");
endmodule : lcd_frame_seq

// file: lcd_glass_panel.sv
`timescale 1ns/1ps
module lcd_glass_panel (
   input  wire logic             aclk,
   input  wire logic [39:0][1:0] seg_lvl,
   input  wire logic [3:0][1:0]  com_lvl,
   input  wire logic [3:0]       com_oe,
   output int                    dc_sum
);
   // the glass is a capacitor, so it integrates the difference between segment 0 and common 0
   // an open common carries no charge, so it adds nothing
   initial dc_sum = 0;
   always @(posedge aclk) begin
      if (com_oe[0]) begin
         dc_sum <= dc_sum + int'(seg_lvl[0]) - int'(com_lvl[0]);
      end
   end
endmodule : lcd_glass_panel

// file: lcd_seg_ctrl_test.sv
`timescale 1ns/1ps
`include "lcd_defs.svh"
module lcd_seg_ctrl_test;
   logic aclk = 0, aresetn = 0, watch_tick = 0, prescaler_enable = 0;
   logic [17:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = '0, rdata, d;
   logic [3:0] wstrb = '0, com_oe;
   logic [1:0] bresp, rresp, r;
   logic [15:0] port_out_data = 16'hffff, port_mode = '0, pullup_opt = 16'hffff;
   logic [15:0] pad_in = 16'hffff, pad_out, pad_oe, pullup_en, port_rdata;
   logic [39:0][1:0] seg_lvl;
   logic [39:0] seg_oe;
   logic [3:0][1:0] com_lvl;
   logic pwr_vdd_en, pwr_bias_short, low_voltage, display_valid;
   logic [3:0] oe_tab [5] = '{4'hf, 4'h7, 4'h3, 4'h7, 4'hf};
   int n_errors = 0, compares = 0, dc_sum, p, dc0;
   always #2.5 aclk = ~aclk;
   lcd_seg_ctrl lcd_seg_ctrl_i (.*);
   lcd_glass_panel lcd_glass_panel_i (.aclk(aclk), .seg_lvl(seg_lvl), .com_lvl(com_lvl),
      .com_oe(com_oe), .dc_sum(dc_sum));
   task automatic results;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task automatic tmo;
      n_errors++;
      $display("Error wait expired");
      results();
   endtask : tmo
   task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : cmp
   task automatic cmp_resp(input logic [1:0] e);
      cmp("response", {30'h0, e}, {30'h0, r});
   endtask : cmp_resp
   task automatic wr(input logic [15:0] idx, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      awvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'h1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 1000);
      bready <= 1'b0;
      r = bresp;
      if (n >= 1000) tmo();
   endtask : wr
   task automatic rd(input logic [15:0] idx);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 1000);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      if (n >= 1000) tmo();
   endtask : rd
   // counts cycles until common 0 changes level
   task automatic flip;
      logic [1:0] c;
      c = com_lvl[0];
      p = 0;
      do begin
         @(posedge aclk);
         p++;
      end while (com_lvl[0] === c && p < 2000);
      if (p >= 2000) tmo();
   endtask : flip
   initial begin
      prescaler_enable = 1'b1; // watch timer runs first
      watch_tick = 1'b1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`LCD_IDX_MODE);
      cmp("mode reset", {24'h0, `LCD_MODE_RST}, d);
      rd(`LCD_IDX_CTRL);
      cmp("ctrl reset", {24'h0, `LCD_CTRL_RST}, d);
      cmp("idle pins", 32'h0000_ffff, {seg_oe[39:24], pad_oe});
      cmp("idle power", 32'h0000_0000, {pwr_vdd_en, pwr_bias_short, display_valid});
      cmp("fixed segments", 32'h00ff_ffff, seg_oe[23:0]);
      wr(16'h0100, 32'h0000_0001);
      cmp_resp(`LCD_RESP_SLV);
      rd(16'h0100);
      cmp_resp(`LCD_RESP_SLV);
      wr(`LCD_IDX_MEM_LO, 32'h0000_ff0f); // upper nibble written as zero
      rd(`LCD_IDX_MEM_LO);
      cmp("memory low", 32'h0000_000f, d);
      wr(`LCD_IDX_MEM_HI, 32'h0000_0005);
      rd(`LCD_IDX_MEM_HI);
      cmp("memory high", 32'h0000_0005, d);
      wr(16'hfa7e, 32'h0000_0000);
      wr(16'hfa7d, 32'h0000_000e); // memory filled before split and mode
      wr(`LCD_IDX_CTRL, 32'h0000_001d);
      rd(`LCD_IDX_CTRL);
      cmp("ctrl", 32'h0000_0011, d);
      @(posedge aclk);
      cmp("main supply", 32'h0000_0001, {pwr_bias_short, pwr_vdd_en});
      cmp("port drive", 32'hfffc_fffc, {pad_out, pad_oe});
      cmp("pull-ups", 32'h0000_fffc, pullup_en);
      cmp("port read", 32'h0000_fffc, port_rdata);
      cmp("split two", 32'h0000_0003, seg_oe[39:24]);
      wr(`LCD_IDX_CTRL, 32'h0000_0082);
      @(posedge aclk);
      cmp("bias pin", 32'h0000_0002, {pwr_bias_short, pwr_vdd_en});
      cmp("split all", 32'hffff_0000, {seg_oe[39:24], pad_oe});
      cmp("pins read", 32'h0000_0000, {pullup_en, port_rdata});
      wr(`LCD_IDX_MODE, 32'h0000_0004);
      repeat (4) @(posedge aclk);
      cmp("display off", seg_lvl[1], seg_lvl[0]);
      for (int k = 0; k < 5; k++) begin
         wr(`LCD_IDX_MODE, 32'(8'hb0 + k));
         repeat (4) @(posedge aclk);
         cmp("commons", oe_tab[k], com_oe);
         // clock code 3 gives 2^6 cycles per slot; two level changes of common 0 span a frame
         if (k < 4) begin
            flip();
            flip();
            dc0 = p;
            flip();
            cmp("frame length", 32'((1 << 6) * $countones(oe_tab[k])), 32'(dc0 + p));
         end
         // code sums are not symmetric at 1/2 bias, so the glass check here stays at 1/3 bias
         if (k < 2) begin
            dc0 = dc_sum;
            repeat (4) flip();
            cmp("dc frames", dc0, dc_sum);
         end
      end
      cmp("static commons", {3{com_lvl[0]}}, {com_lvl[3], com_lvl[2], com_lvl[1]});
      cmp("valid", 32'h0000_0001, display_valid);
      for (int c = 0; c < 4; c++) begin
         wr(`LCD_IDX_MODE, 32'h0000_0084 + 32'(c << 4));
         flip();
         flip();
         cmp("frame period", 32'(1 << (9 - c)), p);
         dc0 = dc_sum;
         flip();
         flip();
         cmp("dc balance", dc0, dc_sum);
      end
      repeat (2) @(posedge aclk);
      cmp("unselect", com_lvl[0], seg_lvl[1]);
      cmp("ignored bits", seg_lvl[1], seg_lvl[2]);
      cmp("select", 32'h0000_0001, seg_lvl[0] !== com_lvl[0]);
      prescaler_enable <= 1'b0;
      repeat (3) @(posedge aclk);
      cmp("stopped", 32'h0000_0000, display_valid);
      d = {30'h0, com_lvl[0]};
      repeat (600) @(posedge aclk);
      cmp("frozen", d, com_lvl[0]);
      wr(`LCD_IDX_MODE, 32'h0000_0000);
      wr(`LCD_IDX_MODE, 32'h0000_0008); // low-voltage set with display off
      @(posedge aclk);
      cmp("low voltage", 32'h0000_0001, low_voltage);
      results();
   end
endmodule : lcd_seg_ctrl_test
